// *** inc/oag_pkg.sv ***
// constants and types shared by the operand address generator
package oag_pkg;

  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned BYTE_W     = 8;
  localparam logic [13:0] PC_RESET   = 14'h3ffd;
  localparam logic [13:0] PC_STEP    = 14'h0001;
  localparam logic [9:0]  TINY_PAD   = 10'h000;
  localparam logic [8:0]  SHORT_PAD  = 9'h000;
  localparam logic [5:0]  DIR_PAD    = 6'h00;

  // opcode groups, low bits carry tiny or short address or bit number
  localparam logic [7:0] OPC_BRANCH_IF_BIT_LOW_BASE = 8'h00;
  localparam logic [7:0] OPC_BRANCH_IF_BIT_HIGH_BASE = 8'h08;
  localparam logic [7:0] OPC_BCOND_BASE = 8'h20;
  localparam logic [7:0] OPC_INC_TINY   = 8'h30;
  localparam logic [7:0] OPC_DEC_TINY   = 8'h40;
  localparam logic [7:0] OPC_ADD_TINY   = 8'h50;
  localparam logic [7:0] OPC_SUB_TINY   = 8'h60;
  localparam logic [7:0] OPC_NOP        = 8'h70;
  localparam logic [7:0] OPC_ENTER_DEBUG_HALT       = 8'h71;
  localparam logic [7:0] OPC_INH_FIRST  = 8'h72;
  localparam logic [7:0] OPC_INH_LAST   = 8'h7f;
  localparam logic [7:0] OPC_CLR_SHORT  = 8'h80;
  localparam logic [7:0] OPC_LDA_SHORT  = 8'ha0;
  localparam logic [7:0] OPC_STA_SHORT  = 8'hc0;
  localparam logic [7:0] OPC_LDA_LIT    = 8'he0;
  localparam logic [7:0] OPC_LDA_DIR    = 8'he1;
  localparam logic [7:0] OPC_STA_DIR    = 8'he2;
  localparam logic [7:0] OPC_COMPARE_BRANCH_EQUAL_DIR   = 8'he3;
  localparam logic [7:0] OPC_DECREMENT_BRANCH_NONZERO_DIR   = 8'he4;
  localparam logic [7:0] OPC_MOV_DD     = 8'he5;
  localparam logic [7:0] OPC_MOV_LD     = 8'he6;
  localparam logic [7:0] OPC_JMP_EXT    = 8'he7;
  localparam logic [7:0] OPC_JSR_EXT    = 8'he8;
  localparam logic [7:0] OPC_ADD_LIT    = 8'he9;
  localparam logic [7:0] OPC_COMPARE_BRANCH_EQUAL_LIT   = 8'hea;

  typedef enum logic [2:0] {
    OAG_MODE_NONE  = 3'b000,
    OAG_MODE_LIT   = 3'b001,
    OAG_MODE_TINY  = 3'b010,
    OAG_MODE_SHORT = 3'b011,
    OAG_MODE_DIR   = 3'b100,
    OAG_MODE_EXT   = 3'b101
  } oag_mode_t;

  typedef enum logic [4:0] {
    OAG_OP_INC   = 5'h00,
    OAG_OP_DEC   = 5'h01,
    OAG_OP_ADD   = 5'h02,
    OAG_OP_SUB   = 5'h03,
    OAG_OP_CLR   = 5'h04,
    OAG_OP_LDA   = 5'h05,
    OAG_OP_STA   = 5'h06,
    OAG_OP_BRANCH_IF_BIT_LOW = 5'h07,
    OAG_OP_BRANCH_IF_BIT_HIGH = 5'h08,
    OAG_OP_BCOND = 5'h09,
    OAG_OP_COMPARE_BRANCH_EQUAL  = 5'h0a,
    OAG_OP_DECREMENT_BRANCH_NONZERO  = 5'h0b,
    OAG_OP_MOV   = 5'h0c,
    OAG_OP_JMP   = 5'h0d,
    OAG_OP_JSR   = 5'h0e,
    OAG_OP_NOP   = 5'h0f,
    OAG_OP_ENTER_DEBUG_HALT  = 5'h10,
    OAG_OP_INH   = 5'h11,
    OAG_OP_ILL   = 5'h12
  } oag_op_t;

  typedef enum logic [2:0] {
    OAG_ST_OPCODE = 3'b000,
    OAG_ST_PLAN   = 3'b001,
    OAG_ST_BYTE1  = 3'b010,
    OAG_ST_BYTE2  = 3'b011,
    OAG_ST_REL    = 3'b100,
    OAG_ST_EXEC   = 3'b101
  } oag_state_t;

endpackage : oag_pkg

// *** inc/oag_dec_if.sv ***
// opcode to addressing plan carrier between sequencer and decoder
`timescale 1ns/1ps
interface oag_dec_if;
  import oag_pkg::*;
  logic [7:0] opcode;
  oag_op_t    op;
  oag_mode_t  src_mode;
  oag_mode_t  dst_mode;
  logic       has_rel;
  logic       illegal;

  modport dec (input opcode, output op, src_mode, dst_mode, has_rel,
               illegal);
  modport seq (output opcode, input op, src_mode, dst_mode, has_rel,
               illegal);
endinterface : oag_dec_if

// *** hdl/oag_decode.sv ***
// combinational opcode decoder for the operand address generator
`timescale 1ns/1ps
module oag_decode
  import oag_pkg::*;
(
  oag_dec_if.dec d
);

  always_comb begin
    d.op       = OAG_OP_ILL;
    d.src_mode = OAG_MODE_NONE;
    d.dst_mode = OAG_MODE_NONE;
    d.has_rel  = 1'b0;
    d.illegal  = 1'b0;
    // (RULE_14) one opcode per mode
    if (d.opcode[7:4] == OPC_BRANCH_IF_BIT_LOW_BASE[7:4]) begin
      // (RULE_12) operand plus offset
      d.op       = d.opcode[3] ? OAG_OP_BRANCH_IF_BIT_HIGH : OAG_OP_BRANCH_IF_BIT_LOW;
      d.src_mode = OAG_MODE_DIR;
      d.has_rel  = 1'b1;
    end else if (d.opcode[7:4] == OPC_BCOND_BASE[7:4]) begin
      d.op      = OAG_OP_BCOND;
      d.has_rel = 1'b1;
    end else if (d.opcode[7:4] == OPC_INC_TINY[7:4] ||
                 d.opcode[7:4] == OPC_DEC_TINY[7:4] ||
                 d.opcode[7:4] == OPC_ADD_TINY[7:4] ||
                 d.opcode[7:4] == OPC_SUB_TINY[7:4]) begin
      // (RULE_05) tiny only for four ops
      d.src_mode = OAG_MODE_TINY;
      unique case (d.opcode[7:4])
        OPC_INC_TINY[7:4]: d.op = OAG_OP_INC;
        OPC_DEC_TINY[7:4]: d.op = OAG_OP_DEC;
        OPC_ADD_TINY[7:4]: d.op = OAG_OP_ADD;
        default:           d.op = OAG_OP_SUB;
      endcase
    end else if (d.opcode >= OPC_INH_FIRST &&
                 d.opcode <= OPC_INH_LAST) begin
      // (RULE_13) internal registers only
      d.op = OAG_OP_INH;
    end else if (d.opcode == OPC_NOP) begin
      // (RULE_13) no operands at all
      d.op = OAG_OP_NOP;
    end else if (d.opcode == OPC_ENTER_DEBUG_HALT) begin
      d.op = OAG_OP_ENTER_DEBUG_HALT;
    end else if (d.opcode[7:5] == OPC_CLR_SHORT[7:5] ||
                 d.opcode[7:5] == OPC_LDA_SHORT[7:5] ||
                 d.opcode[7:5] == OPC_STA_SHORT[7:5]) begin
      // (RULE_07) short only for three ops
      d.src_mode = OAG_MODE_SHORT;
      unique case (d.opcode[7:5])
        OPC_CLR_SHORT[7:5]: d.op = OAG_OP_CLR;
        OPC_LDA_SHORT[7:5]: d.op = OAG_OP_LDA;
        default:            d.op = OAG_OP_STA;
      endcase
    end else begin
      unique case (d.opcode)
        OPC_LDA_LIT: begin
          d.op       = OAG_OP_LDA;
          d.src_mode = OAG_MODE_LIT;
        end
        OPC_ADD_LIT: begin
          d.op       = OAG_OP_ADD;
          d.src_mode = OAG_MODE_LIT;
        end
        OPC_LDA_DIR: begin
          d.op       = OAG_OP_LDA;
          d.src_mode = OAG_MODE_DIR;
        end
        OPC_STA_DIR: begin
          d.op       = OAG_OP_STA;
          d.src_mode = OAG_MODE_DIR;
        end
        OPC_COMPARE_BRANCH_EQUAL_DIR, OPC_COMPARE_BRANCH_EQUAL_LIT: begin
          d.op       = OAG_OP_COMPARE_BRANCH_EQUAL;
          d.src_mode = (d.opcode == OPC_COMPARE_BRANCH_EQUAL_LIT) ? OAG_MODE_LIT
                                                  : OAG_MODE_DIR;
          d.has_rel  = 1'b1;
        end
        OPC_DECREMENT_BRANCH_NONZERO_DIR: begin
          d.op       = OAG_OP_DECREMENT_BRANCH_NONZERO;
          d.src_mode = OAG_MODE_DIR;
          d.has_rel  = 1'b1;
        end
        // (RULE_11) separate source and destination
        OPC_MOV_DD, OPC_MOV_LD: begin
          d.op       = OAG_OP_MOV;
          d.src_mode = (d.opcode == OPC_MOV_LD) ? OAG_MODE_LIT
                                                : OAG_MODE_DIR;
          d.dst_mode = OAG_MODE_DIR;
        end
        // (RULE_10) extended only for jumps
        OPC_JMP_EXT, OPC_JSR_EXT: begin
          d.op       = (d.opcode == OPC_JSR_EXT) ? OAG_OP_JSR
                                                 : OAG_OP_JMP;
          d.src_mode = OAG_MODE_EXT;
        end
        default: d.illegal = 1'b1;
      endcase
    end
  end

endmodule : oag_decode

// *** hdl/oag_top.sv ***
// operand and branch target address sequencer
// What this block does
// (RULE_01) taken branch: pc plus sign-extended offset, else run on sequentially
// (RULE_02) branch base is the address after the last branch byte
// (RULE_03) literal operand is the single 8-bit byte after the opcode
// (RULE_04) tiny address: low four opcode bits with ten zero bits above
// (RULE_05) tiny mode exists only for increment, decrement, add, subtract
// (RULE_06) short address: low five opcode bits with nine zero bits above
// (RULE_07) short mode exists only for clear, load and store accumulator
// (RULE_08) direct address: one byte after opcode with six zero bits above
// (RULE_09) extended address: low 14 bits of the two following bytes
// (RULE_10) extended mode exists only for absolute jump and call
// (RULE_11) moves locate source and destination by separate modes
// (RULE_12) bit branches, compare and decrement branches add a relative offset
// (RULE_13) implied ops fetch no address bytes; nop and debug halt none at all
// (RULE_14) every mode variant of an operation has its own opcode
// (RULE_15) program counter is 14 bits, addressing the next fetch
// (RULE_16) branch target sum wraps within 14 bits
`timescale 1ns/1ps
module oag_top
  import oag_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  output logic             fetch_req,
  output logic [13:0]      fetch_addr,
  input  wire logic        fetch_valid,
  input  wire logic [7:0]  fetch_data,
  output logic             exec_valid,
  output oag_op_t          exec_op,
  output oag_mode_t        exec_src_mode,
  output oag_mode_t        exec_dst_mode,
  output logic [13:0]      exec_src_addr,
  output logic [13:0]      exec_dst_addr,
  output logic [7:0]       exec_literal,
  output logic [13:0]      exec_rel_target,
  output logic [13:0]      exec_jump_target,
  output logic             exec_illegal,
  input  wire logic        exec_done,
  input  wire logic        branch_taken
);

  typedef struct packed {
    oag_state_t  state;
    logic [13:0] pc;
    logic [7:0]  opcode;
    oag_op_t     op;
    oag_mode_t   src_mode;
    oag_mode_t   dst_mode;
    logic        has_rel;
    logic        illegal;
    logic [13:0] src_addr;
    logic [13:0] dst_addr;
    logic [7:0]  literal;
    logic [5:0]  ext_high;
    logic [13:0] rel_target;
    logic [13:0] jump_target;
  } oag_regs_t;

  oag_regs_t   s_reg;
  oag_regs_t   s_next;
  logic [13:0] pc_inc;
  logic [13:0] rel_sext;
  oag_dec_if   dec_bus ();

  assign dec_bus.opcode = s_reg.opcode;

  oag_decode u_decode (
    .d (dec_bus.dec)
  );

  // (RULE_15) pc steps per accepted byte
  assign pc_inc   = s_reg.pc + PC_STEP;
  assign rel_sext = {{(ADDR_W - BYTE_W){fetch_data[7]}}, fetch_data};

  always_comb begin
    s_next = s_reg;
    unique case (s_reg.state)
      OAG_ST_OPCODE: begin
        if (fetch_valid) begin
          s_next.opcode = fetch_data;
          s_next.pc     = pc_inc;
          s_next.state  = OAG_ST_PLAN;
        end
      end
      OAG_ST_PLAN: begin
        s_next.op       = dec_bus.op;
        s_next.src_mode = dec_bus.src_mode;
        s_next.dst_mode = dec_bus.dst_mode;
        s_next.has_rel  = dec_bus.has_rel;
        s_next.illegal  = dec_bus.illegal;
        s_next.src_addr = '0;
        s_next.dst_addr = '0;
        s_next.literal  = '0;
        // (RULE_04) tiny zero extension
        if (dec_bus.src_mode == OAG_MODE_TINY) begin
          s_next.src_addr = {TINY_PAD, s_reg.opcode[3:0]};
        end
        // (RULE_06) short zero extension
        if (dec_bus.src_mode == OAG_MODE_SHORT) begin
          s_next.src_addr = {SHORT_PAD, s_reg.opcode[4:0]};
        end
        // (RULE_13) implied ops skip operand fetch
        if (dec_bus.src_mode == OAG_MODE_LIT ||
            dec_bus.src_mode == OAG_MODE_DIR ||
            dec_bus.src_mode == OAG_MODE_EXT) begin
          s_next.state = OAG_ST_BYTE1;
        end else if (dec_bus.dst_mode == OAG_MODE_DIR) begin
          s_next.state = OAG_ST_BYTE2;
        end else if (dec_bus.has_rel) begin
          s_next.state = OAG_ST_REL;
        end else begin
          s_next.state = OAG_ST_EXEC;
        end
      end
      OAG_ST_BYTE1: begin
        if (fetch_valid) begin
          s_next.pc = pc_inc;
          unique case (s_reg.src_mode)
            // (RULE_03) literal byte after opcode
            OAG_MODE_LIT: s_next.literal = fetch_data;
            // (RULE_08) direct zero extension
            OAG_MODE_DIR: s_next.src_addr = {DIR_PAD, fetch_data};
            default:      s_next.ext_high = fetch_data[5:0];
          endcase
          if (s_reg.src_mode == OAG_MODE_EXT ||
              s_reg.dst_mode == OAG_MODE_DIR) begin
            s_next.state = OAG_ST_BYTE2;
          end else if (s_reg.has_rel) begin
            s_next.state = OAG_ST_REL;
          end else begin
            s_next.state = OAG_ST_EXEC;
          end
        end
      end
      OAG_ST_BYTE2: begin
        if (fetch_valid) begin
          s_next.pc = pc_inc;
          if (s_reg.src_mode == OAG_MODE_EXT) begin
            // (RULE_09) low 14 bits of two bytes
            s_next.jump_target = {s_reg.ext_high, fetch_data};
          end else begin
            // (RULE_11) destination direct address
            s_next.dst_addr = {DIR_PAD, fetch_data};
          end
          s_next.state = s_reg.has_rel ? OAG_ST_REL : OAG_ST_EXEC;
        end
      end
      OAG_ST_REL: begin
        if (fetch_valid) begin
          s_next.pc = pc_inc;
          // (RULE_02) base after last byte
          // (RULE_16) sum wraps in 14 bits
          s_next.rel_target = pc_inc + rel_sext;
          s_next.state      = OAG_ST_EXEC;
        end
      end
      OAG_ST_EXEC: begin
        if (exec_done) begin
          s_next.state = OAG_ST_OPCODE;
          if (s_reg.src_mode == OAG_MODE_EXT) begin
            // (RULE_10) jump loads pc
            s_next.pc = s_reg.jump_target;
          end else if (s_reg.has_rel && branch_taken) begin
            // (RULE_01) taken branch redirects fetch
            s_next.pc = s_reg.rel_target;
          end
        end
      end
      default: s_next.state = OAG_ST_OPCODE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg             <= '0;
      s_reg.state       <= OAG_ST_OPCODE;
      s_reg.pc          <= PC_RESET;
      s_reg.op          <= OAG_OP_NOP;
      s_reg.src_mode    <= OAG_MODE_NONE;
      s_reg.dst_mode    <= OAG_MODE_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  // fetch request stays up in any byte-collecting state
  assign fetch_req = (s_reg.state == OAG_ST_OPCODE) ||
                     (s_reg.state == OAG_ST_BYTE1)  ||
                     (s_reg.state == OAG_ST_BYTE2)  ||
                     (s_reg.state == OAG_ST_REL);
  assign fetch_addr       = s_reg.pc;
  assign exec_valid       = (s_reg.state == OAG_ST_EXEC);
  assign exec_op          = s_reg.op;
  assign exec_src_mode    = s_reg.src_mode;
  assign exec_dst_mode    = s_reg.dst_mode;
  assign exec_src_addr    = s_reg.src_addr;
  assign exec_dst_addr    = s_reg.dst_addr;
  assign exec_literal     = s_reg.literal;
  assign exec_rel_target  = s_reg.rel_target;
  assign exec_jump_target = s_reg.jump_target;
  assign exec_illegal     = s_reg.illegal;

endmodule : oag_top

// *** verif/oag_top_sva.sv ***
// port assertions for the operand address generator
`timescale 1ns/1ps
module oag_top_sva
  import oag_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        fetch_req,
  input wire logic [13:0] fetch_addr,
  input wire logic        fetch_valid,
  input wire logic [7:0]  fetch_data,
  input wire logic        exec_valid,
  input wire oag_op_t     exec_op,
  input wire oag_mode_t   exec_src_mode,
  input wire oag_mode_t   exec_dst_mode,
  input wire logic [13:0] exec_src_addr,
  input wire logic [13:0] exec_dst_addr,
  input wire logic [7:0]  exec_literal,
  input wire logic [13:0] exec_rel_target,
  input wire logic [13:0] exec_jump_target,
  input wire logic        exec_illegal,
  input wire logic        exec_done,
  input wire logic        branch_taken
);
  logic        opc_phase_reg;
  logic [7:0]  opc_reg;
  logic [7:0]  last_reg;
  logic [7:0]  prev_reg;
  logic [13:0] opc_addr_reg;
  logic        take;
  logic        rel_op;
  logic [13:0] rel_sum;
  assign take    = fetch_req && fetch_valid;
  assign rel_op  = exec_op inside {OAG_OP_BRANCH_IF_BIT_LOW, OAG_OP_BRANCH_IF_BIT_HIGH, OAG_OP_BCOND,
                                   OAG_OP_COMPARE_BRANCH_EQUAL, OAG_OP_DECREMENT_BRANCH_NONZERO};
  assign rel_sum = fetch_addr + {{6{last_reg[7]}}, last_reg};
  // first byte after reset or completion is the opcode
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      opc_phase_reg <= 1'b1;
      opc_reg       <= 8'h00;
      last_reg      <= 8'h00;
      prev_reg      <= 8'h00;
      opc_addr_reg  <= 14'h0000;
    end else if (take) begin
      opc_phase_reg <= 1'b0;
      last_reg      <= fetch_data;
      prev_reg      <= last_reg;
      if (opc_phase_reg) begin
        opc_reg      <= fetch_data;
        opc_addr_reg <= fetch_addr;
      end
    end else if (exec_valid && exec_done) begin
      opc_phase_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  fetch_step_a: assert property (
    take |=> fetch_addr == $past(fetch_addr) + 14'h0001)
    else $error("pc did not step after a fetch");
  tiny_addr_a: assert property (
    exec_valid && exec_src_mode == OAG_MODE_TINY
      |-> exec_src_addr == {10'h000, opc_reg[3:0]})
    else $error("tiny address wrong");
  tiny_ops_a: assert property (
    exec_valid && exec_src_mode == OAG_MODE_TINY |-> exec_op inside
      {OAG_OP_INC, OAG_OP_DEC, OAG_OP_ADD, OAG_OP_SUB})
    else $error("tiny mode on wrong operation");
  short_addr_a: assert property (
    exec_valid && exec_src_mode == OAG_MODE_SHORT
      |-> exec_src_addr == {9'h000, opc_reg[4:0]})
    else $error("short address wrong");
  short_ops_a: assert property (
    exec_valid && exec_src_mode == OAG_MODE_SHORT
      |-> exec_op inside {OAG_OP_CLR, OAG_OP_LDA, OAG_OP_STA})
    else $error("short mode on wrong operation");
  dir_addr_a: assert property (
    exec_valid && exec_src_mode == OAG_MODE_DIR && !rel_op
      && exec_op != OAG_OP_MOV |-> exec_src_addr == {6'h00, last_reg})
    else $error("direct address wrong");
  ext_target_a: assert property (
    exec_valid && exec_src_mode == OAG_MODE_EXT
      |-> exec_jump_target == {prev_reg[5:0], last_reg})
    else $error("extended target wrong");
  ext_ops_a: assert property (
    exec_valid && exec_src_mode == OAG_MODE_EXT
      |-> exec_op inside {OAG_OP_JMP, OAG_OP_JSR})
    else $error("extended mode on wrong operation");
  jump_load_a: assert property (
    exec_valid && exec_done && exec_op inside {OAG_OP_JMP, OAG_OP_JSR}
      |=> fetch_addr == $past(exec_jump_target))
    else $error("jump target not loaded");
  rel_target_a: assert property (
    exec_valid && rel_op |-> exec_rel_target == rel_sum)
    else $error("branch target wrong");
  taken_a: assert property (
    exec_valid && exec_done && rel_op |=> fetch_addr == ($past(branch_taken)
      ? $past(exec_rel_target) : $past(fetch_addr)))
    else $error("branch flow wrong");
  implied_a: assert property (
    exec_valid && exec_op inside {OAG_OP_NOP, OAG_OP_ENTER_DEBUG_HALT, OAG_OP_INH}
      |-> exec_src_mode == OAG_MODE_NONE
          && fetch_addr == opc_addr_reg + 14'h0001)
    else $error("implied operation fetched operands");
  literal_a: assert property (
    exec_valid && exec_src_mode == OAG_MODE_LIT && !rel_op
      && exec_op != OAG_OP_MOV |-> exec_literal == last_reg
          && fetch_addr == opc_addr_reg + 14'h0002)
    else $error("literal operand wrong");
  move_a: assert property (
    exec_valid && exec_op == OAG_OP_MOV |-> exec_dst_mode == OAG_MODE_DIR
      && exec_dst_addr == {6'h00, last_reg})
    else $error("move destination wrong");
endmodule : oag_top_sva

// *** verif/oag_fetch_model.sv ***
// program memory behind the instruction fetch path
`timescale 1ns/1ps
module oag_fetch_model (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        fetch_req,
  input  wire logic [13:0] fetch_addr,
  output logic             fetch_valid,
  output logic [7:0]       fetch_data,
  input  wire logic        slow
);
  logic [7:0] mem [0:16383];
  logic       skip_reg;
  logic [7:0] last_reg;
  initial begin
    fetch_valid = 1'b0;
    fetch_data  = 8'h00;
    skip_reg    = 1'b0;
    last_reg    = 8'h00;
  end
  // idle data lines toggle so a stale byte never passes for a fresh one
  always @(posedge core_clk) begin
    #2;
    skip_reg = slow && !skip_reg;
    if (fetch_req && !sys_rst && !skip_reg) begin
      fetch_valid = 1'b1;
      fetch_data  = mem[fetch_addr];
    end else begin
      fetch_valid = 1'b0;
      fetch_data  = ~last_reg;
    end
    last_reg = fetch_data;
  end
endmodule : oag_fetch_model

// *** verif/test_operand_address_generator.sv ***
// self-checking bench for the operand address generator
`timescale 1ns/1ps
module test_operand_address_generator;
  import oag_pkg::*;
  logic        core_clk, sys_rst, fetch_req, fetch_valid, exec_valid;
  logic        exec_illegal, exec_done, branch_taken, slow;
  logic [13:0] fetch_addr, exec_src_addr, exec_dst_addr;
  logic [13:0] exec_rel_target, exec_jump_target;
  logic [7:0]  fetch_data, exec_literal;
  oag_op_t     exec_op;
  oag_mode_t   exec_src_mode, exec_dst_mode;
  int          num_errors, num_checks;
  oag_top u_oag_top (.core_clk(core_clk), .sys_rst(sys_rst),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data),
    .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_src_mode(exec_src_mode), .exec_dst_mode(exec_dst_mode),
    .exec_src_addr(exec_src_addr), .exec_dst_addr(exec_dst_addr),
    .exec_literal(exec_literal), .exec_rel_target(exec_rel_target),
    .exec_jump_target(exec_jump_target), .exec_illegal(exec_illegal),
    .exec_done(exec_done), .branch_taken(branch_taken));
  oag_fetch_model u_oag_fetch_model (.core_clk(core_clk),
    .sys_rst(sys_rst), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data), .slow(slow));
  always #5 core_clk = ~core_clk;
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [13:0] got, input logic [13:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : cmp
  task automatic put(input logic [13:0] a, input logic [7:0] b[$]);
    foreach (b[i]) u_oag_fetch_model.mem[a + 14'(i)] = b[i];
  endtask : put
  // waits for a decoded instruction, judges it, then completes it
  task automatic step(input oag_op_t op, input oag_mode_t md,
      input logic [13:0] sa, input logic [7:0] lit, input logic take);
    int n;
    n = 0;
    while (exec_valid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    cmp(14'(exec_op), 14'(op), "operation");
    cmp(14'(exec_src_mode), 14'(md), "source mode");
    cmp(exec_src_addr, sa, "source address");
    cmp(14'(exec_literal), 14'(lit), "literal");
    cmp(14'(exec_illegal), 14'(op == OAG_OP_ILL), "illegal flag");
    exec_done = 1'b1;
    branch_taken = take;
    @(posedge core_clk);
    #1;
    exec_done = 1'b0;
    branch_taken = 1'b0;
  endtask : step
  // reset, then jump to a; high bits of the address byte must be ignored
  task automatic start(input logic [13:0] a);
    sys_rst = 1'b1;
    put(PC_RESET, '{8'he7, {2'b11, a[13:8]}, a[7:0]});
    repeat (3) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    step(OAG_OP_JMP, OAG_MODE_EXT, 14'h0000, 8'h00, 1'b0);
    cmp(fetch_addr, a, "jump target");
  endtask : start
  task automatic t_reset;
    put(PC_RESET, '{8'h70});
    repeat (3) @(posedge core_clk);
    #1;
    cmp(fetch_addr, 14'h3ffd, "reset address");
    cmp(14'(exec_valid), 14'h0000, "idle in reset");
    cmp(14'(fetch_req), 14'h0001, "fetch request in reset");
    sys_rst = 1'b0;
    step(OAG_OP_NOP, OAG_MODE_NONE, 14'h0000, 8'h00, 1'b0);
    cmp(fetch_addr, 14'h3ffe, "nop length");
  endtask : t_reset
  task automatic t_modes;
    oag_op_t ops[13] = '{OAG_OP_INC, OAG_OP_DEC, OAG_OP_ADD, OAG_OP_SUB,
      OAG_OP_CLR, OAG_OP_LDA, OAG_OP_STA, OAG_OP_LDA, OAG_OP_LDA,
      OAG_OP_INH, OAG_OP_NOP, OAG_OP_ENTER_DEBUG_HALT, OAG_OP_ILL};
    oag_mode_t mds[13] = '{OAG_MODE_TINY, OAG_MODE_TINY, OAG_MODE_TINY,
      OAG_MODE_TINY, OAG_MODE_SHORT, OAG_MODE_SHORT, OAG_MODE_SHORT,
      OAG_MODE_LIT, OAG_MODE_DIR, OAG_MODE_NONE, OAG_MODE_NONE,
      OAG_MODE_NONE, OAG_MODE_NONE};
    logic [13:0] sas[13] = '{14'h0005, 14'h000f, 14'h000a, 14'h000c,
      14'h001f, 14'h0003, 14'h001f, 14'h0000, 14'h0080, 14'h0000,
      14'h0000, 14'h0000, 14'h0000};
    put(14'h0010, '{8'h35, 8'h4f, 8'h5a, 8'h6c, 8'h9f, 8'ha3, 8'hdf,
      8'he0, 8'ha5, 8'he1, 8'h80, 8'h72, 8'h70, 8'h71, 8'h1f});
    start(14'h0010);
    for (int i = 0; i < 13; i++) begin
      step(ops[i], mds[i], sas[i], (i == 7) ? 8'ha5 : 8'h00, 1'b0);
    end
  endtask : t_modes
  task automatic t_branch;
    put(14'h0000, '{8'h20, 8'h80});
    put(14'h3f82, '{8'h20, 8'h7f, 8'h0b, 8'h12, 8'hfe, 8'he9, 8'h55,
      8'he4, 8'h33, 8'h02});
    start(14'h0000);
    step(OAG_OP_BCOND, OAG_MODE_NONE, 14'h0000, 8'h00, 1'b1);
    cmp(fetch_addr, 14'h3f82, "backward branch");
    step(OAG_OP_BCOND, OAG_MODE_NONE, 14'h0000, 8'h00, 1'b0);
    cmp(fetch_addr, 14'h3f84, "untaken branch");
    cmp(exec_rel_target, 14'h0003, "wrapped target");
    step(OAG_OP_BRANCH_IF_BIT_HIGH, OAG_MODE_DIR, 14'h0012, 8'h00, 1'b0);
    cmp(exec_rel_target, 14'h3f85, "bit branch target");
    step(OAG_OP_ADD, OAG_MODE_LIT, 14'h0000, 8'h55, 1'b0);
    step(OAG_OP_DECREMENT_BRANCH_NONZERO, OAG_MODE_DIR, 14'h0033, 8'h00, 1'b1);
    cmp(fetch_addr, 14'h3f8e, "decrement branch taken");
  endtask : t_branch
  // stalling fetch path while moves, compare branch and call decode
  task automatic t_pair;
    slow = 1'b1;
    put(14'h0100, '{8'he5, 8'h10, 8'h20, 8'he3, 8'h40, 8'h05, 8'he6,
      8'h77, 8'h30, 8'he8, 8'h00, 8'h40});
    start(14'h0100);
    step(OAG_OP_MOV, OAG_MODE_DIR, 14'h0010, 8'h00, 1'b0);
    cmp(exec_dst_addr, 14'h0020, "move destination");
    cmp(14'(exec_dst_mode), 14'(OAG_MODE_DIR), "move mode");
    step(OAG_OP_COMPARE_BRANCH_EQUAL, OAG_MODE_DIR, 14'h0040, 8'h00, 1'b0);
    cmp(exec_rel_target, 14'h010b, "compare target");
    step(OAG_OP_MOV, OAG_MODE_LIT, 14'h0000, 8'h77, 1'b0);
    cmp(exec_dst_addr, 14'h0030, "literal move");
    step(OAG_OP_JSR, OAG_MODE_EXT, 14'h0000, 8'h00, 1'b0);
    cmp(fetch_addr, 14'h0040, "call target");
    slow = 1'b0;
  endtask : t_pair
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    exec_done = 1'b0;
    branch_taken = 1'b0;
    slow = 1'b0;
    num_errors = 0;
    num_checks = 0;
    t_reset;
    t_modes;
    t_branch;
    t_pair;
    complete_run;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    num_errors++;
    complete_run;
  end
endmodule : test_operand_address_generator
bind oag_top oag_top_sva u_oag_top_sva (.core_clk(core_clk),
  .sys_rst(sys_rst), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
  .fetch_valid(fetch_valid), .fetch_data(fetch_data),
  .exec_valid(exec_valid), .exec_op(exec_op),
  .exec_src_mode(exec_src_mode), .exec_dst_mode(exec_dst_mode),
  .exec_src_addr(exec_src_addr), .exec_dst_addr(exec_dst_addr),
  .exec_literal(exec_literal), .exec_rel_target(exec_rel_target),
  .exec_jump_target(exec_jump_target), .exec_illegal(exec_illegal),
  .exec_done(exec_done), .branch_taken(branch_taken));
